/* fan_one_params.svh */
`ifndef FAN_ONE_PARAMS_SVH
`define FAN_ONE_PARAMS_SVH
// register addresses
`define FAN_ONE_SOURCE_BINDING_ADDR 8'hc8
`define FAN_ONE_OVERRIDE_AND_LOCK_ADDR 8'hc9
`define FAN_ONE_SPINUP_CONFIG_ADDR 8'hca
// reset values
`define FAN_ONE_SOURCE_BINDING_RESET 8'h00
`define FAN_ONE_OVERRIDE_AND_LOCK_RESET 8'h00
`define FAN_ONE_SPINUP_CONFIG_RESET 8'h00
// field positions in the override and lock register
`define MANUAL_DUTY_ENABLE_BIT 0
`define OUTPUT_POLARITY_INVERT_BIT 1
`define HOT_LOCK_ENABLE_BIT 2
`define HOT_FULL_SPEED_LOCK_FLAG_BIT 3
// field positions in the binding register
`define PROC_HOT_ONE_BIND_BIT 4
`define PROC_HOT_TWO_BIND_BIT 5
// full-scale duty code and pwm frame
`define DUTY_CODE_FULL 4'hf
`define PWM_FRAME_STEPS 4'hf
// clock and spin-up time base
`define CLOCK_MHZ 125
`define SPINUP_UNIT_MS 50
`define SPINUP_UNIT_CYCLES (`SPINUP_UNIT_MS * 1000 * `CLOCK_MHZ)
`endif

/* fan_one_pkg.sv */
package fan_one_pkg;
  // spin-up sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_spin = 2'b01
  } spin_state_type;
  typedef logic [3:0] duty_code_type;
  typedef logic [7:0] reg_byte_type;
endpackage : fan_one_pkg

/* fan_one_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fan_one_params.svh"
// What this block does
// - binding bits 0..3 attach the fan output to lookup zones one to four
// - binding bits 4 and 5 attach processor-hot inputs one and two
// - binding bits 6 and 7 attach regulator-hot inputs one and two
// - zones request duty via table lookup; hot inputs via ramp functions
// - with several sources bound, the largest requested duty is driven
// - control bit 0 enables manual override using the override duty field
// - polarity bit 1 zero gives full duty high; one gives full duty low
// - with lock enable set a bound processor-hot event sets the lock flag
// - lock flag holds full duty until software writes zero to it
// - the lock flag ignores the global configuration write-lock
// - four-bit override code in bits 7:4 picks one of 16 duties
// - reading the override field returns the duty actually in use
// - during spin-up the override field reads as zero
// - spin-up duty code in bits 3:0; zero disables spin-up
// - spin-up starts whenever duty goes from zero to non-zero
// - duration code is bit 4 as msb and bits 7:5 as lsbs
// - duration codes map to 0, 100 ms up to 4 s, then 6 s to 20 s
module fan_one_pwm #(
  parameter int unsigned SPINUP_UNIT_CYCLES = `SPINUP_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic reg_write,
  input wire fan_one_pkg::reg_byte_type reg_addr,
  input wire fan_one_pkg::reg_byte_type reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic config_write_lock,
  // duty requests from lookup zones and ramps
  input wire fan_one_pkg::duty_code_type lookup_zone_duty [4],
  input wire fan_one_pkg::duty_code_type proc_hot_ramp_duty [2],
  input wire fan_one_pkg::duty_code_type regulator_hot_ramp_duty [2],
  // hot event inputs
  input wire logic processor_one_hot_input,
  input wire logic processor_two_hot_input,
  input wire logic regulator_one_hot_input,
  input wire logic regulator_two_hot_input,
  // fan drive
  output logic first_fan_output,
  output logic spinup_active,
  output fan_one_pkg::duty_code_type duty_in_use
);
  import fan_one_pkg::*;

  reg_byte_type binding_q;
  reg_byte_type override_q;
  reg_byte_type spinup_q;
  logic lock_flag_q;
  spin_state_type spin_state_q;
  logic [31:0] unit_count_q;
  logic [8:0] units_left_q;
  duty_code_type arb_duty;
  duty_code_type duty_d;
  duty_code_type duty_q;
  duty_code_type last_arb_q;
  logic [3:0] spinup_duration_code;
  logic [8:0] spinup_units;
  logic proc_hot_event;
  logic [3:0] pwm_step_q;
  logic wr_bind;
  logic wr_ovr;
  logic wr_spin;

  assign wr_bind = reg_write && reg_addr == `FAN_ONE_SOURCE_BINDING_ADDR && !config_write_lock;
  assign wr_ovr = reg_write && reg_addr == `FAN_ONE_OVERRIDE_AND_LOCK_ADDR;
  assign wr_spin = reg_write && reg_addr == `FAN_ONE_SPINUP_CONFIG_ADDR && !config_write_lock;

  // binding register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      binding_q <= `FAN_ONE_SOURCE_BINDING_RESET;
    end else if (wr_bind) begin
      binding_q <= reg_wdata;
    end
  end

  // override and control bits, write-lock protected
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      override_q <= `FAN_ONE_OVERRIDE_AND_LOCK_RESET;
    end else if (wr_ovr && !config_write_lock) begin
      override_q <= reg_wdata;
    end
  end

  // spin-up configuration
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      spinup_q <= `FAN_ONE_SPINUP_CONFIG_RESET;
    end else if (wr_spin) begin
      spinup_q <= reg_wdata;
    end
  end

  // bound processor-hot event
  assign proc_hot_event = (binding_q[`PROC_HOT_ONE_BIND_BIT] && processor_one_hot_input) ||
                          (binding_q[`PROC_HOT_TWO_BIND_BIT] && processor_two_hot_input);

  // lock flag: set wins over the zero write, write-lock not applied
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_flag_q <= 1'b0;
    end else if (override_q[`HOT_LOCK_ENABLE_BIT] && proc_hot_event) begin
      lock_flag_q <= 1'b1;
    end else if (wr_ovr && !reg_wdata[`HOT_FULL_SPEED_LOCK_FLAG_BIT]) begin
      lock_flag_q <= 1'b0;
    end
  end

  // largest request over bound sources, override and lock
  always_comb begin
    arb_duty = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (binding_q[i] && lookup_zone_duty[i] > arb_duty) begin
        arb_duty = lookup_zone_duty[i];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (binding_q[4 + i] && proc_hot_ramp_duty[i] > arb_duty) begin
        arb_duty = proc_hot_ramp_duty[i];
      end
      if (binding_q[6 + i] && regulator_hot_ramp_duty[i] > arb_duty) begin
        arb_duty = regulator_hot_ramp_duty[i];
      end
    end
    if (override_q[`MANUAL_DUTY_ENABLE_BIT] && override_q[7:4] > arb_duty) begin
      arb_duty = override_q[7:4];
    end
    if (lock_flag_q) begin
      arb_duty = `DUTY_CODE_FULL;
    end
  end

  // duration code assembly and unit lookup, units of 50 ms
  assign spinup_duration_code = {spinup_q[4], spinup_q[7:5]};
  always_comb begin
    case (spinup_duration_code)
      4'h0: spinup_units = 9'd0;
      4'h1: spinup_units = 9'd2;
      4'h2: spinup_units = 9'd5;
      4'h3: spinup_units = 9'd8;
      4'h4: spinup_units = 9'd14;
      4'h5: spinup_units = 9'd20;
      4'h6: spinup_units = 9'd40;
      4'h7: spinup_units = 9'd80;
      default: spinup_units = 9'(({5'd0, spinup_duration_code} - 9'd5) * 9'd40);
    endcase
  end

  // previous arbitrated duty for zero-to-nonzero detection
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_arb_q <= 4'h0;
    end else begin
      last_arb_q <= arb_duty;
    end
  end

  // spin-up sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      spin_state_q <= st_idle;
      unit_count_q <= 32'h0;
      units_left_q <= 9'h0;
    end else begin
      case (spin_state_q)
        st_idle: begin
          if (last_arb_q == 4'h0 && arb_duty != 4'h0 && spinup_q[3:0] != 4'h0
              && spinup_units != 9'd0) begin
            spin_state_q <= st_spin;
            units_left_q <= spinup_units;
            unit_count_q <= 32'h0;
          end
        end
        st_spin: begin
          if (unit_count_q == SPINUP_UNIT_CYCLES - 1) begin
            unit_count_q <= 32'h0;
            if (units_left_q == 9'd1) begin
              spin_state_q <= st_idle;
            end
            units_left_q <= units_left_q - 9'd1;
          end else begin
            unit_count_q <= unit_count_q + 32'h1;
          end
        end
        default: spin_state_q <= st_idle;
      endcase
    end
  end
  assign spinup_active = spin_state_q == st_spin;

  // duty in use: spin-up duty during spin-up, else arbitrated duty
  always_comb begin
    duty_d = spinup_active ? spinup_q[3:0] : arb_duty;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      duty_q <= 4'h0;
    end else begin
      duty_q <= duty_d;
    end
  end
  assign duty_in_use = duty_q;

  // pwm frame counter, 15 steps
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwm_step_q <= 4'h0;
    end else if (pwm_step_q == `PWM_FRAME_STEPS - 4'h1) begin
      pwm_step_q <= 4'h0;
    end else begin
      pwm_step_q <= pwm_step_q + 4'h1;
    end
  end

  // output with polarity; code 15 is continuously on
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      first_fan_output <= 1'b0;
    end else begin
      first_fan_output <= (pwm_step_q < duty_q) ^ override_q[`OUTPUT_POLARITY_INVERT_BIT];
    end
  end

  // readback
  always_comb begin
    case (reg_addr)
      `FAN_ONE_SOURCE_BINDING_ADDR: reg_rdata = binding_q;
      `FAN_ONE_OVERRIDE_AND_LOCK_ADDR: reg_rdata = {spinup_active ? 4'h0 : duty_q,
        lock_flag_q, override_q[2:0]};
      `FAN_ONE_SPINUP_CONFIG_ADDR: reg_rdata = spinup_q;
      default: reg_rdata = 8'h00;
    endcase
  end
endmodule : fan_one_pwm
`default_nettype wire

/* fan_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_motor_model (
  // clock and fan drive
  input wire logic clock,
  input wire logic drive,
  // high time seen over the last frame
  output int on_count
);
  logic [14:0] hist_q;
  // slide a one-frame window over the drive
  always_ff @(posedge clock) hist_q <= {hist_q[13:0], drive};
  assign on_count = $countones(hist_q);
endmodule : fan_motor_model
`default_nettype wire

/* fan_one_pwm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_one_pwm_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic reg_write,
  input wire fan_one_pkg::reg_byte_type reg_addr,
  input wire fan_one_pkg::reg_byte_type reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic config_write_lock,
  // fan side
  input wire logic processor_one_hot_input,
  input wire logic processor_two_hot_input,
  input wire logic first_fan_output,
  input wire logic spinup_active,
  input wire fan_one_pkg::duty_code_type duty_in_use
);
  import fan_one_pkg::*;
  logic [7:0] bnd_q;
  logic [7:0] cfg_q;
  logic inv_q;
  wire logic wok = reg_write && !config_write_lock;
  // shadows of the lockable configuration
  always_ff @(posedge clock)
    if (sys_rst) bnd_q <= 8'h00;
    else if (wok && reg_addr == 8'hc8) bnd_q <= reg_wdata;
  always_ff @(posedge clock)
    if (sys_rst) cfg_q <= 8'h00;
    else if (wok && reg_addr == 8'hca) cfg_q <= reg_wdata;
  always_ff @(posedge clock)
    if (sys_rst) inv_q <= 1'b0;
    else if (wok && reg_addr == 8'hc9) inv_q <= reg_wdata[1];
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_bind; reg_addr == 8'hc8 |-> reg_rdata == bnd_q; endproperty
  a_bind: assert property (p_bind) else $error("binding readback wrong");
  property p_use; reg_addr == 8'hc9 && !spinup_active |-> reg_rdata[7:4] == duty_in_use;
  endproperty
  a_use: assert property (p_use) else $error("duty readback wrong");
  property p_zero; reg_addr == 8'hc9 && spinup_active |-> reg_rdata[7:4] == 4'h0; endproperty
  a_zero: assert property (p_zero) else $error("duty read during spin-up");
  property p_inv; duty_in_use == 4'hf && $past(duty_in_use) == 4'hf
    && $past(inv_q) == inv_q && $past(inv_q, 2) == inv_q |-> first_fan_output != inv_q;
  endproperty
  a_inv: assert property (p_inv) else $error("full duty level wrong");
  property p_clr; reg_write && reg_addr == 8'hc9 && config_write_lock && !reg_wdata[3]
    && !processor_one_hot_input && !processor_two_hot_input ##1 reg_addr == 8'hc9
    |-> !reg_rdata[3];
  endproperty
  a_clr: assert property (p_clr) else $error("lock flag not cleared");
  property p_nolock; reg_addr == 8'hc9 && $past(reg_addr) == 8'hc9 && !$past(reg_write)
    && $past(reg_rdata[3:2]) == 2'b00 |-> !reg_rdata[3];
  endproperty
  a_nolock: assert property (p_nolock) else $error("lock set while disabled");
  property p_hold; reg_addr == 8'hc9 && $past(reg_addr) == 8'hc9 && reg_rdata[3]
    && $past(reg_rdata[3]) && !spinup_active && !$past(spinup_active) |-> duty_in_use == 4'hf;
  endproperty
  a_hold: assert property (p_hold) else $error("lock not at full duty");
  property p_spin; $rose(spinup_active) |-> $past(cfg_q[3:0]) != 4'h0
    && $past(cfg_q[7:4]) != 4'h0;
  endproperty
  a_spin: assert property (p_spin) else $error("spin-up while disabled");
  property p_sdc; $rose(spinup_active) |-> ##[0:1] duty_in_use == cfg_q[3:0]; endproperty
  a_sdc: assert property (p_sdc) else $error("spin-up duty wrong");
endmodule : fan_one_pwm_monitor
bind fan_one_pwm fan_one_pwm_monitor mon (.clock(clock), .sys_rst(sys_rst),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .config_write_lock(config_write_lock), .processor_one_hot_input(processor_one_hot_input),
  .processor_two_hot_input(processor_two_hot_input), .first_fan_output(first_fan_output),
  .spinup_active(spinup_active), .duty_in_use(duty_in_use));
`default_nettype wire

/* fan_one_pwm_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_one_pwm_test;
  import fan_one_pkg::*;
  logic clock = 0, sys_rst = 1, reg_write = 0, cfg_lock = 0, fan, spin;
  logic [1:0] hot = 2'b00, rg = 2'b00;
  reg_byte_type reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, b, c, bn = 0, ct = 0;
  duty_code_type lz [4] = '{default: 4'h0}, ph [2] = '{default: 4'h0};
  duty_code_type rh [2] = '{default: 4'h0}, duty_in_use;
  int n_mismatch = 0, checked = 0, e, i, k, w, on;
  int dur [16] = '{0, 2, 5, 8, 14, 20, 40, 80, 120, 160, 200, 240, 280, 320, 360, 400};
  logic [7:0] lb [3] = '{8'h30, 8'h10, 8'h20}, lc [3] = '{8'h00, 8'h04, 8'h04};
  fan_one_pwm #(.SPINUP_UNIT_CYCLES(4)) dut (.clock(clock), .sys_rst(sys_rst),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .config_write_lock(cfg_lock), .lookup_zone_duty(lz), .proc_hot_ramp_duty(ph),
    .regulator_hot_ramp_duty(rh), .processor_one_hot_input(hot[0]),
    .processor_two_hot_input(hot[1]), .regulator_one_hot_input(rg[0]),
    .regulator_two_hot_input(rg[1]), .first_fan_output(fan), .spinup_active(spin),
    .duty_in_use(duty_in_use));
  fan_motor_model fan_m (.clock(clock), .drive(fan), .on_count(on));
  // clock generator
  initial forever #4 clock = ~clock;
  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [15:0] got, input int exp);
    checked++;
    if (got !== 16'(exp)) begin
      n_mismatch++;
      $display("ERROR %0t got %0h want %0h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    @(negedge clock);
    reg_write = 0;
    @(negedge clock);
  endtask : wr
  // reference arbitration: largest bound request, lock forces full
  function automatic int want(logic [7:0] bd, logic [7:0] cl);
    int m;
    int v;
    m = 0;
    for (int j = 0; j < 8; j++) begin
      v = j < 4 ? lz[j] : j < 6 ? ph[j - 4] : rh[j - 6];
      if (bd[j] && v > m) m = v;
    end
    if (cl[0] && cl[7:4] > m) m = cl[7:4];
    return cl[3] ? 15 : m;
  endfunction : want
  // main sequence
  initial begin
    i = $urandom(13609);
    repeat (5) @(negedge clock);
    sys_rst = 0;
    for (i = 0; i < 4; i++) begin
      reg_addr = 8'hc8 + 8'(i);
      #1 cmp(reg_rdata, 0); // reset values and unmapped read
    end
    @(negedge clock);
    for (i = 0; i < 30; i++) begin
      foreach (lz[j]) lz[j] = $urandom;
      foreach (ph[j]) ph[j] = $urandom;
      foreach (rh[j]) rh[j] = $urandom;
      {cfg_lock, rg} = 3'($urandom);
      b = $urandom;
      c = $urandom & 8'hf3;
      wr(8'hc8, b);
      wr(8'hc9, c);
      if (!cfg_lock) bn = b;
      if (!cfg_lock) ct = c;
      repeat (18) @(negedge clock);
      w = want(bn, ct);
      cmp(duty_in_use, w);
      cmp(reg_rdata, {w[3:0], ct[3:0]});
      cmp(on, ct[1] ? 15 - w : w);
    end
    cfg_lock = 0;
    foreach (lz[j]) lz[j] = 0;
    foreach (ph[j]) ph[j] = 0;
    foreach (rh[j]) rh[j] = 0;
    for (e = 0; e < 3; e++) begin
      cfg_lock = 0;
      wr(8'hc8, lb[e]);
      wr(8'hc9, lc[e]);
      hot = e ? 2'b10 : 2'b11;
      @(negedge clock);
      hot = 2'b00;
      repeat (3) @(negedge clock);
      cmp(duty_in_use, e == 2 ? 15 : 0);
      cfg_lock = 1;
      wr(8'hc9, 8'h00);
      cmp(reg_rdata, lc[e]);
    end
    cfg_lock = 0;
    wr(8'hc8, 8'h01);
    wr(8'hc9, 8'h00);
    for (i = 0; i < 16; i++) begin
      k = i == 1 ? 0 : 1 + $urandom % 15;
      wr(8'hca, {i[2:0], i[3], k[3:0]});
      lz[0] = 4'h5;
      reg_addr = 8'hc9;
      e = 0;
      repeat (1700) begin
        @(negedge clock);
        e += int'(spin === 1'b1);
      end
      cmp(e, k ? dur[i] * 4 : 0);
      cmp(duty_in_use, 5);
      lz[0] = 4'h0;
      repeat (3) @(negedge clock);
    end
    complete_run();
  end
endmodule : fan_one_pwm_test
`default_nettype wire
